// ### hdl/ambient_source_command_handler.sv
// Ambient source command handler: set/query of temperature and pressure
// sources per setup, and read-all of the five ambient conditions.
// Assumes parsed commands and sensor values on the same clock.
// Function
// - Temperature source command has set form and query form taking only the setup index
// - Setup index accepted only from 1 to 21
// - Setup 21 usable only from remote communication
// - Temperature source is internal, factory default or user value
// - Measurement value accepted only with user source, else rejected
// - User temperature must be 0 to 50 degC inclusive
// - User pressure must be 70 to 110 kPa absolute
// - Setup 1 stays internal and refuses any change
// - Every source reply carries source and value with unit
// - External pressure choice switches every externally sourced setup
// - Errors: 1 bad setup, 2 bad source, 3 bad value
// - Read-all takes no argument, values from active setup sources
// - Read-all lists each value with unit, comma separated
// - Read-all fields have fixed units and decimals
// - Order: pressure, vacuum, humidity, ambient temp, piston temp
// - Vacuum field meaningful only with bell jar fitted
`timescale 1ns/100ps
module ambient_source_command_handler import amb_src_pkg::*; #(
   parameter meas_t DEFAULT_TEMP = 24'sh0007d0,
   parameter meas_t DEFAULT_PRESS = 24'sh0f7602
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Parsed command
   input wire logic cmd_valid_in,
   input wire cmd_t cmd_in,
   output logic cmd_ready_out,
   // Environment
   input wire logic [4:0] active_setup_in,
   input wire logic bell_jar_fitted_in,
   input wire sensor_t sensors_in,
   // Reply
   output logic rsp_valid_out,
   output rsp_t rsp_out,
   output amb_all_t all_out
);

   typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_SWEEP_RD, ST_SWEEP_WR}
      state_t;

   state_t state, next_state;
   cmd_t cmd, next_cmd;
   rsp_t next_rsp;
   amb_all_t next_all;
   logic next_rsp_valid;
   logic [4:0] sweep_idx, next_sweep_idx;
   logic [2:0] sweep_src, next_sweep_src;

   logic [4:0] rd_addr, wr_addr;
   logic wr_en;
   setup_entry_t mem_q, entry_new;
   logic is_set, is_temp, setup_bad, src_bad, meas_bad;
   logic [1:0] err;

   function automatic logic [4:0] slot_of(logic [4:0] setup);
      if (setup >= SETUP_MIN && setup <= SETUP_MAX) begin
         slot_of = setup - SETUP_MIN;
      end else begin
         slot_of = 5'h00;
      end
   endfunction

   function automatic meas_t temp_of(setup_entry_t e, sensor_t s);
      case (e.temp_src)
         SRC_USER: temp_of = e.temp_user;
         SRC_DEFAULT: temp_of = DEFAULT_TEMP;
         default: temp_of = s.temp;
      endcase
   endfunction

   function automatic meas_t press_of(setup_entry_t e, sensor_t s);
      case (e.press_src)
         SRC_USER: press_of = e.press_user;
         SRC_DEFAULT: press_of = DEFAULT_PRESS;
         SRC_EXT_REF: press_of = s.ext_ref_press;
         SRC_BARO: press_of = s.baro_press;
         default: press_of = s.press;
      endcase
   endfunction

   function automatic logic is_external(logic [2:0] src);
      is_external = (src == SRC_EXT_REF) || (src == SRC_BARO);
   endfunction

   // One entry per setup, slot = setup - 1
   setup_store #(
      .DEPTH(SETUP_DEPTH),
      .AW(SETUP_AW)
   ) u_store (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .rd_addr_in(rd_addr),
      .rd_data_out(mem_q),
      .wr_en_in(wr_en),
      .wr_addr_in(wr_addr),
      .wr_data_in(entry_new)
   );

   // Validation of the held command
   assign is_set = (cmd.kind == CMD_TEMP_SET) || (cmd.kind == CMD_PRESS_SET);
   assign is_temp = (cmd.kind == CMD_TEMP_SET) ||
                    (cmd.kind == CMD_TEMP_QUERY);
   assign setup_bad = (cmd.setup < SETUP_MIN) || (cmd.setup > SETUP_MAX) ||
      (cmd.setup == SETUP_REMOTE_ONLY && !cmd.remote) ||
      (is_set && cmd.setup == SETUP_FIXED);
   assign src_bad = is_set && (is_temp ? (cmd.source > SRC_USER)
                                       : (cmd.source > SRC_BARO));
   assign meas_bad = is_set && cmd.has_meas && ((cmd.source != SRC_USER) ||
      (is_temp ? (cmd.meas < TEMP_USER_MIN ||
                  cmd.meas > TEMP_USER_MAX)
               : (cmd.meas < PRESS_USER_MIN ||
                  cmd.meas > PRESS_USER_MAX)));

   always_comb begin
      if (cmd.kind == CMD_READ_ALL) begin
         err = ERR_NONE;
      end else if (setup_bad) begin
         err = ERR_SETUP;
      end else if (src_bad) begin
         err = ERR_SOURCE;
      end else if (meas_bad) begin
         err = ERR_MEAS;
      end else begin
         err = ERR_NONE;
      end
   end

   // Entry after a successful set, or with press_src set to sweep_src during the sweep
   always_comb begin
      entry_new = mem_q;
      if (state == ST_SWEEP_WR) begin
         entry_new.press_src = sweep_src;
      end else if (cmd.kind == CMD_TEMP_SET) begin
         entry_new.temp_src = cmd.source;
         if (cmd.has_meas) begin
            entry_new.temp_user = cmd.meas;
         end
      end else if (cmd.kind == CMD_PRESS_SET) begin
         entry_new.press_src = cmd.source;
         if (cmd.has_meas) begin
            entry_new.press_user = cmd.meas;
         end
      end
   end

   assign cmd_ready_out = (state == ST_IDLE);

   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_rsp = rsp_out;
      next_all = all_out;
      next_rsp_valid = 1'b0;
      next_sweep_idx = sweep_idx;
      next_sweep_src = sweep_src;
      rd_addr = sweep_idx;
      wr_addr = slot_of(cmd.setup);
      wr_en = 1'b0;
      case (state)
         ST_IDLE: begin
            rd_addr = (cmd_in.kind == CMD_READ_ALL) ? slot_of(active_setup_in)
                                                    : slot_of(cmd_in.setup);
            if (cmd_valid_in) begin
               next_cmd = cmd_in;
               next_state = ST_EVAL;
            end
         end
         ST_EVAL: begin
            next_rsp.err = err;
            next_rsp.src = 3'h0;
            next_rsp.value = '0;
            next_rsp.unit = UNIT_KPAA;
            if (cmd.kind == CMD_READ_ALL) begin
               next_all.press = press_of(mem_q, sensors_in);
               next_all.vacuum_present = bell_jar_fitted_in;
               next_all.vacuum = bell_jar_fitted_in ? sensors_in.vacuum
                                                    : '0;
               next_all.humidity = sensors_in.humidity;
               next_all.amb_temp = temp_of(mem_q, sensors_in);
               next_all.piston_temp = sensors_in.piston_temp;
               next_rsp_valid = 1'b1;
               next_state = ST_IDLE;
            end else begin
               if (err == ERR_NONE) begin
                  wr_en = is_set;
                  next_rsp.src = is_temp ? entry_new.temp_src
                                         : entry_new.press_src;
                  next_rsp.value = is_temp ? temp_of(entry_new, sensors_in)
                                           : press_of(entry_new, sensors_in);
                  next_rsp.unit = is_temp ? UNIT_DC : UNIT_KPAA;
               end
               if (err == ERR_NONE && cmd.kind == CMD_PRESS_SET &&
                   is_external(cmd.source)) begin
                  next_sweep_idx = 5'h00;
                  next_sweep_src = cmd.source;
                  next_state = ST_SWEEP_RD;
               end else begin
                  next_rsp_valid = 1'b1;
                  next_state = ST_IDLE;
               end
            end
         end
         ST_SWEEP_RD: begin
            next_state = ST_SWEEP_WR;
         end
         ST_SWEEP_WR: begin
            wr_addr = sweep_idx;
            wr_en = is_external(mem_q.press_src) &&
                    (mem_q.press_src != sweep_src);
            if (sweep_idx == SETUP_MAX - SETUP_MIN) begin
               next_rsp_valid = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_sweep_idx = sweep_idx + 5'h01;
               next_state = ST_SWEEP_RD;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         cmd <= '0;
         rsp_out <= '0;
         all_out <= '0;
         rsp_valid_out <= 1'b0;
         sweep_idx <= 5'h00;
         sweep_src <= SRC_INTERNAL;
      end else begin
         state <= next_state;
         cmd <= next_cmd;
         rsp_out <= next_rsp;
         all_out <= next_all;
         rsp_valid_out <= next_rsp_valid;
         sweep_idx <= next_sweep_idx;
         sweep_src <= next_sweep_src;
      end
   end

   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   logic ok_setup;
   assign ok_setup = cmd.setup > SETUP_FIXED && cmd.setup < SETUP_MAX;

   a_reply_bounded: assert property (
      cmd_valid_in && cmd_ready_out |-> ##[2:60] rsp_valid_out)
      else $error("no reply within bound");
   a_setup_range: assert property (
      rsp_valid_out && cmd.kind != CMD_READ_ALL &&
      (cmd.setup == 5'h00 || cmd.setup > SETUP_MAX)
      |-> rsp_out.err == ERR_SETUP)
      else $error("out of range setup not refused");
   a_remote_only: assert property (
      rsp_valid_out && cmd.kind != CMD_READ_ALL &&
      cmd.setup == SETUP_REMOTE_ONLY && !cmd.remote
      |-> rsp_out.err == ERR_SETUP)
      else $error("local use of remote setup accepted");
   a_temp_source: assert property (
      rsp_valid_out && cmd.kind == CMD_TEMP_SET && ok_setup &&
      cmd.source > SRC_USER |-> rsp_out.err == ERR_SOURCE)
      else $error("bad temperature source accepted");
   a_meas_source: assert property (
      rsp_valid_out && is_set && ok_setup && !src_bad && cmd.has_meas &&
      cmd.source != SRC_USER |-> rsp_out.err == ERR_MEAS)
      else $error("value with non-user source accepted");
   a_temp_limit: assert property (
      rsp_valid_out && cmd.kind == CMD_TEMP_SET && ok_setup &&
      cmd.source == SRC_USER && cmd.has_meas && cmd.meas > TEMP_USER_MAX
      |-> rsp_out.err == ERR_MEAS)
      else $error("temperature above limit accepted");
   a_press_limit: assert property (
      rsp_valid_out && cmd.kind == CMD_PRESS_SET && ok_setup &&
      cmd.source == SRC_USER && cmd.has_meas && cmd.meas < PRESS_USER_MIN
      |-> rsp_out.err == ERR_MEAS)
      else $error("pressure below limit accepted");
   a_slot_one_fixed: assert property (
      wr_en |-> wr_addr != 5'h00)
      else $error("setup one written");
   a_error_no_write: assert property (
      state == ST_EVAL && err != ERR_NONE |-> !wr_en ##1 !wr_en)
      else $error("rejected command wrote store");
   a_reply_unit: assert property (
      state == ST_EVAL && is_temp && err == ERR_NONE
      |=> rsp_valid_out && rsp_out.unit == UNIT_DC)
      else $error("temperature reply lacks unit");
   a_vacuum_gated: assert property (
      state == ST_EVAL && cmd.kind == CMD_READ_ALL && !bell_jar_fitted_in
      |=> !all_out.vacuum_present && all_out.vacuum == '0)
      else $error("vacuum shown without bell jar");

   c_temp_set: cover property (
      rsp_valid_out && cmd.kind == CMD_TEMP_SET && rsp_out.err == ERR_NONE);
   c_error: cover property (rsp_valid_out && rsp_out.err != ERR_NONE);
   c_read_all: cover property (rsp_valid_out && cmd.kind == CMD_READ_ALL);
   c_sweep: cover property (state == ST_SWEEP_WR && wr_en);

endmodule

// ### inc/amb_src_pkg.sv
// Shared constants and carriers for the ambient source command handler.
// Assumes commands arrive already parsed from text into cmd_t fields.
package amb_src_pkg;

   // Setup index range and special slots
   localparam logic [4:0] SETUP_MIN = 5'h01;
   localparam logic [4:0] SETUP_MAX = 5'h15;
   localparam logic [4:0] SETUP_FIXED = 5'h01;
   localparam logic [4:0] SETUP_REMOTE_ONLY = 5'h15;
   localparam int SETUP_AW = 5;
   localparam int SETUP_DEPTH = 21;

   // Source codes as carried in a command
   localparam logic [2:0] SRC_INTERNAL = 3'h0;
   localparam logic [2:0] SRC_DEFAULT = 3'h1;
   localparam logic [2:0] SRC_USER = 3'h2;
   localparam logic [2:0] SRC_EXT_REF = 3'h3;
   localparam logic [2:0] SRC_BARO = 3'h4;

   // Error codes in a reply
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_SETUP = 2'h1;
   localparam logic [1:0] ERR_SOURCE = 2'h2;
   localparam logic [1:0] ERR_MEAS = 2'h3;

   typedef logic signed [23:0] meas_t;

   // Temperature in 0.01 degC, pressure in 0.0001 kPa absolute
   localparam meas_t TEMP_USER_MIN = 24'sh000000;
   localparam meas_t TEMP_USER_MAX = 24'sh001388;
   localparam meas_t PRESS_USER_MIN = 24'sh0aae60;
   localparam meas_t PRESS_USER_MAX = 24'sh10c8e0;

   // Read-all text layout: field count, separator, decimals per field
   localparam int ALL_FIELDS = 5;
   localparam logic [7:0] ALL_SEPARATOR = 8'h2c;
   localparam logic [2:0] DEC_PRESS = 3'h4;
   localparam logic [2:0] DEC_VACUUM = 3'h1;
   localparam logic [2:0] DEC_HUMIDITY = 3'h0;
   localparam logic [2:0] DEC_TEMP = 3'h2;

   typedef enum logic [2:0] {
      CMD_TEMP_SET, CMD_TEMP_QUERY, CMD_PRESS_SET, CMD_PRESS_QUERY,
      CMD_READ_ALL
   } cmd_kind_t;

   typedef enum logic [1:0] {UNIT_KPAA, UNIT_PAA, UNIT_PCT, UNIT_DC} unit_t;

   typedef struct packed {
      cmd_kind_t kind;
      logic [4:0] setup;
      logic [2:0] source;
      logic has_meas;
      meas_t meas;
      logic remote;
   } cmd_t;

   typedef struct packed {
      logic [2:0] temp_src;
      meas_t temp_user;
      logic [2:0] press_src;
      meas_t press_user;
   } setup_entry_t;

   typedef struct packed {
      logic [1:0] err;
      logic [2:0] src;
      meas_t value;
      unit_t unit;
   } rsp_t;

   // Vacuum in 0.1 Pa, humidity in whole percent
   typedef struct packed {
      meas_t temp;
      meas_t press;
      meas_t ext_ref_press;
      meas_t baro_press;
      meas_t vacuum;
      logic [7:0] humidity;
      meas_t piston_temp;
   } sensor_t;

   // Fields in reply order, first field in the top bits
   typedef struct packed {
      meas_t press;
      meas_t vacuum;
      logic vacuum_present;
      logic [7:0] humidity;
      meas_t amb_temp;
      meas_t piston_temp;
   } amb_all_t;

   // Value after reset of every stored setup
   localparam setup_entry_t ENTRY_RESET = '{
      temp_src: SRC_INTERNAL, temp_user: 24'sh0007d0,
      press_src: SRC_INTERNAL, press_user: 24'sh0f7602};

endpackage

// ### hdl/setup_store.sv
// Stored source configuration per setup, one read and one write port.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/100ps
module setup_store import amb_src_pkg::*; #(
   parameter int DEPTH = SETUP_DEPTH,
   parameter int AW = SETUP_AW
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Read port
   input wire logic [AW-1:0] rd_addr_in,
   output setup_entry_t rd_data_out,
   // Write port
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire setup_entry_t wr_data_in
);

   if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_depth
      $error("setup_store depth does not fit the address width");
   end

   setup_entry_t mem [DEPTH];

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= ENTRY_RESET;
         end
         rd_data_out <= ENTRY_RESET;
      end else begin
         if (wr_en_in && int'(wr_addr_in) < DEPTH) begin
            mem[wr_addr_in] <= wr_data_in;
         end
         rd_data_out <= (int'(rd_addr_in) < DEPTH) ? mem[rd_addr_in]
                                                   : ENTRY_RESET;
      end
   end

endmodule

// ### tb/amb_host_model.sv
// Host model: offers parsed commands and collects one reply each.
// Assumes the handler clock; outputs change just after rising edges.
`timescale 1ns/100ps
module amb_host_model import amb_src_pkg::*; (
   // Clock
   input wire logic clk_in,
   // Command
   input wire logic cmd_ready_in,
   output logic cmd_valid_out,
   output cmd_t cmd_out,
   // Reply
   input wire logic rsp_valid_in,
   input wire rsp_t rsp_in
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_out = '0;
   end

   // Idle gap, offer until taken, then wait for the reply
   task automatic issue(input cmd_t c, input int gap, output rsp_t r,
      output bit late);
      bit hit;
      int n;
      r = '0;
      repeat (gap) @(posedge clk_in);
      @(posedge clk_in);
      cmd_valid_out <= 1'b1;
      cmd_out <= c;
      hit = 1'b0;
      for (n = 0; n < 100 && !hit; n++) begin
         @(negedge clk_in);
         hit = cmd_ready_in === 1'b1;
         @(posedge clk_in);
      end
      late = !hit;
      // Released lines show no stale command
      cmd_valid_out <= 1'b0;
      cmd_out <= ~c;
      hit = 1'b0;
      for (n = 0; n < 100 && !hit; n++) begin
         @(negedge clk_in);
         hit = rsp_valid_in === 1'b1;
         r = rsp_in;
      end
      late = late || !hit;
   endtask
endmodule

// ### tb/tb_top.sv
// Bench: random and corner commands, every reply predicted.
// Assumes the handler, its package and the host model compiled.
`timescale 1ns/100ps
module tb_top import amb_src_pkg::*;;
   localparam meas_t DEF_T = 24'sh0007d0;
   localparam meas_t DEF_P = 24'sh0f7602;
   logic clk_in = 1'b0;
   logic rst_n_in, cmd_valid, cmd_ready, rsp_valid, bell_jar;
   logic [4:0] active_setup;
   cmd_t cmd;
   rsp_t rsp, got, exp;
   amb_all_t all, eall;
   sensor_t sensors;
   int fails = 0;
   int n_checks = 0;
   logic [2:0] t_src [1:21];
   logic [2:0] p_src [1:21];
   meas_t t_usr [1:21];
   meas_t p_usr [1:21];

   always #2 clk_in = ~clk_in;

   ambient_source_command_handler #(.DEFAULT_TEMP(DEF_T),
      .DEFAULT_PRESS(DEF_P)) ambient_source_command_handler_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid),
      .cmd_in(cmd), .cmd_ready_out(cmd_ready),
      .active_setup_in(active_setup), .bell_jar_fitted_in(bell_jar),
      .sensors_in(sensors), .rsp_valid_out(rsp_valid), .rsp_out(rsp),
      .all_out(all));

   amb_host_model amb_host_model_inst (.clk_in(clk_in),
      .cmd_ready_in(cmd_ready), .cmd_valid_out(cmd_valid),
      .cmd_out(cmd), .rsp_valid_in(rsp_valid), .rsp_in(rsp));

   function automatic meas_t tval(logic [2:0] s, meas_t u);
      return s == SRC_USER ? u : s == SRC_DEFAULT ? DEF_T : sensors.temp;
   endfunction

   function automatic meas_t pval(logic [2:0] s, meas_t u);
      return s == SRC_USER ? u : s == SRC_DEFAULT ? DEF_P :
         s == SRC_EXT_REF ? sensors.ext_ref_press :
         s == SRC_BARO ? sensors.baro_press : sensors.press;
   endfunction

   function automatic rsp_t predict(cmd_t c);
      rsp_t e;
      bit tp, st;
      int s;
      e = '0;
      s = c.setup;
      tp = c.kind inside {CMD_TEMP_SET, CMD_TEMP_QUERY};
      st = c.kind inside {CMD_TEMP_SET, CMD_PRESS_SET};
      if (c.kind == CMD_READ_ALL) return e;
      if (s < 1 || s > 21 || (s == 21 && !c.remote) || (st && s == 1))
         e.err = ERR_SETUP;
      else if (st && c.source > (tp ? SRC_USER : SRC_BARO))
         e.err = ERR_SOURCE;
      else if (st && c.has_meas && (c.source != SRC_USER || (tp ?
         (c.meas < TEMP_USER_MIN || c.meas > TEMP_USER_MAX) :
         (c.meas < PRESS_USER_MIN || c.meas > PRESS_USER_MAX))))
         e.err = ERR_MEAS;
      if (e.err != ERR_NONE) return e;
      if (st && tp) begin
         t_src[s] = c.source;
         if (c.has_meas) t_usr[s] = c.meas;
      end else if (st) begin
         p_src[s] = c.source;
         if (c.has_meas) p_usr[s] = c.meas;
         for (int i = 1; i <= 21; i++)
            if (c.source > SRC_USER && p_src[i] > SRC_USER)
               p_src[i] = c.source;
      end
      e.src = tp ? t_src[s] : p_src[s];
      e.value = tp ? tval(t_src[s], t_usr[s]) : pval(p_src[s], p_usr[s]);
      e.unit = tp ? UNIT_DC : UNIT_KPAA;
      return e;
   endfunction

   function automatic amb_all_t predict_all();
      amb_all_t a;
      int s;
      s = active_setup;
      a.press = pval(p_src[s], p_usr[s]);
      a.vacuum = bell_jar ? sensors.vacuum : '0;
      a.vacuum_present = bell_jar;
      a.humidity = sensors.humidity;
      a.amb_temp = tval(t_src[s], t_usr[s]);
      a.piston_temp = sensors.piston_temp;
      return a;
   endfunction

   function automatic cmd_t mk(cmd_kind_t k, int s, int src, int hm,
      int m, int rem);
      cmd_t c;
      c.kind = k;
      c.setup = 5'(s);
      c.source = 3'(src);
      c.has_meas = 1'(hm);
      c.meas = meas_t'(m);
      c.remote = 1'(rem);
      return c;
   endfunction

   task automatic check(string what, logic [127:0] seen, logic [127:0] ex);
      n_checks++;
      if (seen !== ex) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, ex, seen);
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic do_cmd(cmd_t c, int gap);
      bit late;
      exp = predict(c);
      eall = predict_all();
      amb_host_model_inst.issue(c, gap, got, late);
      if (late) begin
         fails++;
         finish_test();
      end
   endtask

   task automatic do_reset();
      rst_n_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      @(negedge clk_in);
      check("ready in reset", 128'(cmd_ready), 128'(1'b1));
      check("reply in reset", 128'({rsp_valid, rsp}), 128'(0));
      check("fields in reset", 128'(all), 128'(0));
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (int s = 1; s <= 21; s++) begin
         t_src[s] = ENTRY_RESET.temp_src;
         t_usr[s] = ENTRY_RESET.temp_user;
         p_src[s] = ENTRY_RESET.press_src;
         p_usr[s] = ENTRY_RESET.press_user;
      end
   endtask

   task automatic new_env(bit bj);
      @(posedge clk_in);
      sensors <= {$urandom, $urandom, $urandom, $urandom, 24'($urandom)};
      active_setup <= 5'($urandom_range(21, 1));
      bell_jar <= bj;
      @(posedge clk_in);
   endtask

   task automatic sweep();
      for (int s = 1; s <= 21; s++) begin
         do_cmd(mk(CMD_TEMP_QUERY, s, 0, 0, 0, 1), s % 3);
         check("temp query", 128'(got), 128'(exp));
         do_cmd(mk(CMD_PRESS_QUERY, s, 0, 0, 0, 1), 0);
         check("press query", 128'(got), 128'(exp));
      end
   endtask

   initial begin
      cmd_t good [11];
      cmd_t bad [12];
      cmd_kind_t k;
      active_setup = 5'h02;
      bell_jar = 1'b0;
      sensors = '0;
      void'($urandom(32'h151c));
      do_reset();
      new_env(1'b1);
      sweep();
      $display("test reset_values done");
      good = '{mk(CMD_TEMP_SET, 2, 2, 1, 0, 1),
         mk(CMD_TEMP_SET, 21, 2, 1, 5000, 1),
         mk(CMD_TEMP_SET, 4, 1, 0, 0, 1), mk(CMD_TEMP_SET, 21, 2, 0, 0, 1),
         mk(CMD_TEMP_SET, 3, 0, 0, 0, 1),
         mk(CMD_PRESS_SET, 5, 2, 1, 700000, 1),
         mk(CMD_PRESS_SET, 21, 2, 1, 1100000, 1),
         mk(CMD_PRESS_SET, 6, 1, 0, 0, 1), mk(CMD_PRESS_SET, 7, 3, 0, 0, 1),
         mk(CMD_PRESS_SET, 8, 4, 0, 0, 1), mk(CMD_PRESS_SET, 9, 3, 0, 0, 1)};
      foreach (good[i]) begin
         do_cmd(good[i], i % 2);
         check("set reply", 128'(got), 128'(exp));
      end
      $display("test good_sets done");
      bad = '{mk(CMD_TEMP_SET, 0, 7, 1, 1, 1),
         mk(CMD_PRESS_QUERY, 22, 0, 0, 0, 1),
         mk(CMD_TEMP_QUERY, 21, 0, 0, 0, 0), mk(CMD_TEMP_SET, 1, 0, 0, 0, 1),
         mk(CMD_TEMP_SET, 3, 3, 1, 1, 1), mk(CMD_PRESS_SET, 5, 5, 0, 0, 1),
         mk(CMD_TEMP_SET, 2, 1, 1, 100, 1), mk(CMD_TEMP_SET, 2, 2, 1, 5001, 1),
         mk(CMD_TEMP_SET, 2, 2, 1, -1, 1),
         mk(CMD_PRESS_SET, 5, 2, 1, 699999, 1),
         mk(CMD_PRESS_SET, 5, 2, 1, 1100001, 1),
         mk(CMD_PRESS_SET, 7, 0, 1, 800000, 1)};
      foreach (bad[i]) begin
         do_cmd(bad[i], 0);
         check("error reply", 128'(got), 128'(exp));
      end
      sweep();
      $display("test errors done");
      check("separator", 128'(ALL_SEPARATOR), 128'(8'h2c));
      check("press decimals", 128'(DEC_PRESS), 128'(3'h4));
      check("vacuum decimals", 128'(DEC_VACUUM), 128'(3'h1));
      check("humid decimals", 128'(DEC_HUMIDITY), 128'(3'h0));
      check("temp decimals", 128'(DEC_TEMP), 128'(3'h2));
      for (int i = 0; i < 8; i++) begin
         new_env(i[0]);
         do_cmd(mk(CMD_READ_ALL, 0, 0, 0, 0, 1), 0);
         check("all error", 128'(got.err), 128'(ERR_NONE));
         check("all fields", 128'(all), 128'(eall));
      end
      $display("test read_all done");
      for (int i = 0; i < 300; i++) begin
         if (i % 10 == 0) new_env(1'($urandom));
         k = cmd_kind_t'($urandom_range(4));
         do_cmd(mk(k, $urandom_range(22), $urandom_range(5),
            $urandom_range(1), k inside {CMD_TEMP_SET, CMD_TEMP_QUERY} ?
            $urandom_range(5100) - 50 : 690000 + $urandom_range(420000),
            $urandom_range(7) != 0), $urandom_range(2));
         check("random reply", 128'(got.err), 128'(exp.err));
         if (k != CMD_READ_ALL)
            check("random value", 128'(got), 128'(exp));
         else
            check("random all", 128'(all), 128'(eall));
      end
      sweep();
      $display("test random done");
      @(posedge clk_in);
      do_reset();
      sweep();
      $display("test second_reset done");
      finish_test();
   end
endmodule
